// ---- core/dbs_params.svh ----
// Constants for the dynamic bus sizing link
// Operation
// - Both width requests negated means 32-bit cycle
// - Both width requests asserted means 8-bit cycle
// - Decoder asserts width request matching target width
// - Half width splits dword into two cycles
// - Byte width splits dword into four cycles
// - Decoder keeps width request during follow-on cycles
// - Follow-on cycles get remaining lanes, same address
// - Byte width next-lane table
// - Half width next-lane table
// - Memory targets ignore lane selects on line cycles
// - Bytes travel only on their addressed lanes
// - Steering returns read data on expected lanes
// - Write data valid only on selected lanes
// - Width sampled every clock, used before ready
// - Buffered writes finish before any I/O cycle
// - 4 GB memory and 64 KB I/O range
// - I/O space holds byte, word, dword ports
`ifndef DBS_PARAMS_SVH
`define DBS_PARAMS_SVH
`define DBS_IO_ADDR_MASK 32'h0000ffff
`define DBS_LANES_NONE_N 4'hf
`define DBS_LANES_ALL 4'hf
`define DBS_LOW_HALF 4'h3
`define DBS_HIGH_HALF 4'hc
`define DBS_WAIT_STATES 4'h1
`define DBS_MEM8_TAG 4'hf
`define DBS_MEM16_TAG 4'he
`define DBS_IO8_TAG 4'h0
`define DBS_IO16_TAG 4'h1
`endif

// ---- core/dbs_pkg.sv ----
// Types shared by both ends of the sizing link
package dbs_pkg;
    typedef enum logic [2:0] {
        DBS_W32 = 3'b001,
        DBS_W16 = 3'b010,
        DBS_W8 = 3'b100
    } dbs_width_e;
endpackage

// ---- core/dbs_bus_if.sv ----
// Processor bus between the sizing end and the peripheral decoder
interface dbs_bus_if;
    logic addrStrobeN;
    logic [31:2] addr;
    logic [3:0] laneSelectN;
    logic ioCycle;
    logic writeCycle;
    logic lineCycle;
    logic [31:0] cpuData;
    logic cpuDataOe;
    logic [31:0] perData;
    logic perDataOe;
    logic [31:0] data;
    logic readyN;
    logic halfWidthRequestN;
    logic byteWidthRequestN;

    // Shared data pins; undriven pins read as zero
    assign data = cpuDataOe ? cpuData : (perDataOe ? perData : 32'h0);

    modport cpu (
        output addrStrobeN, addr, laneSelectN, ioCycle, writeCycle,
        output lineCycle, cpuData, cpuDataOe,
        input data, readyN, halfWidthRequestN, byteWidthRequestN
    );
    modport periph (
        input addrStrobeN, addr, laneSelectN, ioCycle, writeCycle,
        input lineCycle, data,
        output perData, perDataOe, readyN,
        output halfWidthRequestN, byteWidthRequestN
    );
endinterface

// ---- core/dbs_cpu_end.sv ----
// Processor end: splits requests by sampled bus width
`include "dbs_params.svh"
module dbs_cpu_end (
    input wire logic clk,
    input wire logic rst_b,
    dbs_bus_if.cpu bus,
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqWrite,
    input wire logic reqIo,
    input wire logic reqLine,
    input wire logic [31:0] reqAddr,
    input wire logic [3:0] reqLanesN,
    input wire logic [31:0] reqWrData,
    output logic respValid,
    output logic [31:0] respData,
    output logic writesPending
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ADDR = 3'b010,
        ST_DATA = 3'b100
    } dbs_cpu_state_e;

    dbs_cpu_state_e state;
    dbs_pkg::dbs_width_e widthSample;
    dbs_pkg::dbs_width_e liveWidth;

    logic slotValid;
    logic slotWrite;
    logic slotIo;
    logic slotLine;
    logic slotPosted;
    logic [31:0] slotAddr;
    logic [3:0] slotActive;
    logic [31:0] slotWrData;

    logic curWrite;
    logic curPosted;
    logic [3:0] curActive;
    logic [31:0] curWrData;
    logic [31:0] rdBuf;

    logic accept;
    logic launch;
    logic ioBlocked;
    logic cycleDone;
    logic [3:0] validMask;
    logic [3:0] remaining;
    logic [31:0] next_rdBuf;

    function automatic dbs_pkg::dbs_width_e widthOf(logic halfN, logic byteN);
        if (!byteN) begin
            return dbs_pkg::DBS_W8;
        end else if (!halfN) begin
            return dbs_pkg::DBS_W16;
        end
        return dbs_pkg::DBS_W32;
    endfunction

    // Lanes served by one cycle at the given width; the rest carry over
    function automatic logic [3:0] servedLanes(logic [3:0] act,
                                               dbs_pkg::dbs_width_e w);
        logic [3:0] lowest;
        lowest = act & (~act + 4'h1);
        case (w)
            dbs_pkg::DBS_W8: return lowest;
            dbs_pkg::DBS_W16: begin
                if (act[1:0] != 2'b00) begin
                    return act & `DBS_LOW_HALF;
                end
                return act & `DBS_HIGH_HALF;
            end
            default: return act;
        endcase
    endfunction

    // Drive only selected lanes; no copies onto idle lanes
    function automatic logic [31:0] maskData(logic [31:0] d, logic [3:0] act);
        logic [31:0] m;
        m = 32'h0;
        for (int k = 0; k < 4; k++) begin
            if (act[k]) begin
                m[k*8 +: 8] = d[k*8 +: 8];
            end
        end
        return m;
    endfunction

    assign liveWidth = widthOf(bus.halfWidthRequestN, bus.byteWidthRequestN);
    assign accept = reqValid && reqReady;
    // I/O waits until the engine holds no buffered write
    assign ioBlocked = slotIo && state != ST_IDLE;
    assign launch = slotValid && state == ST_IDLE && !ioBlocked;
    assign cycleDone = state == ST_DATA && !bus.readyN;
    assign validMask = servedLanes(curActive, widthSample);
    assign remaining = curActive & ~validMask;

    always_comb begin
        next_rdBuf = rdBuf;
        for (int k = 0; k < 4; k++) begin
            if (validMask[k]) begin
                next_rdBuf[k*8 +: 8] = bus.data[k*8 +: 8];
            end
        end
    end

    // Width pins are sampled every clock; ready uses the prior sample
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            widthSample <= dbs_pkg::DBS_W32;
        end else begin
            widthSample <= liveWidth;
        end
    end

    // Request slot: memory writes are posted and answered at once
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            slotValid <= 1'b0;
            slotWrite <= 1'b0;
            slotIo <= 1'b0;
            slotLine <= 1'b0;
            slotPosted <= 1'b0;
            slotAddr <= 32'h0;
            slotActive <= 4'h0;
            slotWrData <= 32'h0;
            reqReady <= 1'b0;
        end else begin
            if (accept) begin
                slotValid <= 1'b1;
                slotWrite <= reqWrite;
                slotIo <= reqIo;
                slotLine <= reqLine && !reqIo && !reqWrite;
                slotPosted <= reqWrite && !reqIo;
                if (reqIo) begin
                    slotAddr <= reqAddr & `DBS_IO_ADDR_MASK;
                end else begin
                    slotAddr <= reqAddr;
                end
                slotActive <= ~reqLanesN;
                slotWrData <= reqWrData;
            end else if (launch) begin
                slotValid <= 1'b0;
            end
            reqReady <= !(slotValid && !launch) && !accept;
        end
    end

    // Bus engine
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            bus.addrStrobeN <= 1'b1;
            bus.addr <= 30'h0;
            bus.laneSelectN <= `DBS_LANES_NONE_N;
            bus.ioCycle <= 1'b0;
            bus.writeCycle <= 1'b0;
            bus.lineCycle <= 1'b0;
            bus.cpuData <= 32'h0;
            bus.cpuDataOe <= 1'b0;
            curWrite <= 1'b0;
            curPosted <= 1'b0;
            curActive <= 4'h0;
            curWrData <= 32'h0;
            rdBuf <= 32'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (launch) begin
                        state <= ST_ADDR;
                        bus.addrStrobeN <= 1'b0;
                        bus.addr <= slotAddr[31:2];
                        bus.laneSelectN <= ~slotActive;
                        bus.ioCycle <= slotIo;
                        bus.writeCycle <= slotWrite;
                        bus.lineCycle <= slotLine;
                        bus.cpuData <= maskData(slotWrData, slotActive);
                        bus.cpuDataOe <= slotWrite;
                        curWrite <= slotWrite;
                        curPosted <= slotPosted;
                        curActive <= slotActive;
                        curWrData <= slotWrData;
                        rdBuf <= 32'h0;
                    end
                end
                ST_ADDR: begin
                    bus.addrStrobeN <= 1'b1;
                    state <= ST_DATA;
                end
                ST_DATA: begin
                    if (cycleDone) begin
                        rdBuf <= next_rdBuf;
                        if (remaining != 4'h0) begin
                            // Follow-on cycle keeps the dword address
                            state <= ST_ADDR;
                            bus.addrStrobeN <= 1'b0;
                            bus.laneSelectN <= ~remaining;
                            bus.cpuData <= maskData(curWrData, remaining);
                            curActive <= remaining;
                        end else begin
                            state <= ST_IDLE;
                            bus.laneSelectN <= `DBS_LANES_NONE_N;
                            bus.cpuDataOe <= 1'b0;
                            bus.writeCycle <= 1'b0;
                            bus.lineCycle <= 1'b0;
                            curActive <= 4'h0;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Answers: posted writes at acceptance, the rest at their last cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            respValid <= 1'b0;
            respData <= 32'h0;
            writesPending <= 1'b0;
        end else begin
            respValid <= (accept && reqWrite && !reqIo) ||
                (cycleDone && remaining == 4'h0 && !curPosted);
            if (cycleDone && remaining == 4'h0 && !curWrite) begin
                respData <= next_rdBuf;
            end
            writesPending <= (slotValid && slotWrite) ||
                (state != ST_IDLE && curWrite) || (accept && reqWrite);
        end
    end
endmodule // dbs_cpu_end

// ---- core/dbs_periph_end.sv ----
// Peripheral end: width decode and byte steering for narrow targets
`include "dbs_params.svh"
module dbs_periph_end #(
    parameter logic [3:0] WAIT_STATES = `DBS_WAIT_STATES,
    parameter logic [3:0] MEM8_TAG = `DBS_MEM8_TAG,
    parameter logic [3:0] MEM16_TAG = `DBS_MEM16_TAG,
    parameter logic [3:0] IO8_TAG = `DBS_IO8_TAG,
    parameter logic [3:0] IO16_TAG = `DBS_IO16_TAG
) (
    input wire logic clk,
    input wire logic rst_b,
    dbs_bus_if.periph bus,
    output logic tgtStrobe,
    output logic tgtWrite,
    output logic tgtIo,
    output logic [31:0] tgtAddr,
    output logic [3:0] tgtLanesN,
    output dbs_pkg::dbs_width_e tgtWidth,
    output logic [31:0] tgtWrData,
    input wire logic [31:0] tgtRdData
);
    logic busy;
    logic [3:0] waitCnt;
    logic [3:0] curActive;
    dbs_pkg::dbs_width_e curWidth;
    dbs_pkg::dbs_width_e decWidth;
    logic [3:0] decActive;
    logic [3:0] lowest;
    logic [31:0] steerRd;

    always_comb begin
        decWidth = dbs_pkg::DBS_W32;
        if (bus.ioCycle) begin
            if (bus.addr[15:12] == IO8_TAG) begin
                decWidth = dbs_pkg::DBS_W8;
            end else if (bus.addr[15:12] == IO16_TAG) begin
                decWidth = dbs_pkg::DBS_W16;
            end
        end else if (bus.addr[31:28] == MEM8_TAG) begin
            decWidth = dbs_pkg::DBS_W8;
        end else if (bus.addr[31:28] == MEM16_TAG) begin
            decWidth = dbs_pkg::DBS_W16;
        end
        // Line fills to memory take every lane regardless of selects
        if (bus.lineCycle && !bus.ioCycle) begin
            decActive = `DBS_LANES_ALL;
        end else begin
            decActive = ~bus.laneSelectN;
        end
    end

    // Put the target's native data back on the addressed lanes
    assign lowest = curActive & (~curActive + 4'h1);
    always_comb begin
        steerRd = 32'h0;
        case (curWidth)
            dbs_pkg::DBS_W8: begin
                for (int k = 0; k < 4; k++) begin
                    if (lowest[k]) begin
                        steerRd[k*8 +: 8] = tgtRdData[7:0];
                    end
                end
            end
            dbs_pkg::DBS_W16: begin
                if (curActive[1:0] != 2'b00) begin
                    steerRd[15:0] = tgtRdData[15:0];
                end else begin
                    steerRd[31:16] = tgtRdData[15:0];
                end
            end
            default: steerRd = tgtRdData;
        endcase
    end

    // Width requests are set at the strobe and held to the next one
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus.halfWidthRequestN <= 1'b1;
            bus.byteWidthRequestN <= 1'b1;
        end else if (!bus.addrStrobeN) begin
            // Byte I/O targets pull both requests; the byte width wins
            bus.halfWidthRequestN <= decWidth == dbs_pkg::DBS_W32 ||
                (decWidth == dbs_pkg::DBS_W8 && !bus.ioCycle);
            bus.byteWidthRequestN <= decWidth != dbs_pkg::DBS_W8;
        end
    end

    // Target access; ready waits so width stands the clock before it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
            waitCnt <= 4'h0;
            curActive <= 4'h0;
            curWidth <= dbs_pkg::DBS_W32;
            bus.readyN <= 1'b1;
            bus.perData <= 32'h0;
            bus.perDataOe <= 1'b0;
            tgtStrobe <= 1'b0;
            tgtWrite <= 1'b0;
            tgtIo <= 1'b0;
            tgtAddr <= 32'h0;
            tgtLanesN <= `DBS_LANES_NONE_N;
            tgtWidth <= dbs_pkg::DBS_W32;
            tgtWrData <= 32'h0;
        end else begin
            tgtStrobe <= 1'b0;
            bus.readyN <= 1'b1;
            bus.perDataOe <= 1'b0;
            if (!bus.addrStrobeN) begin
                busy <= 1'b1;
                waitCnt <= WAIT_STATES;
                curActive <= decActive;
                curWidth <= decWidth;
                tgtStrobe <= 1'b1;
                tgtWrite <= bus.writeCycle;
                tgtIo <= bus.ioCycle;
                tgtAddr <= {bus.addr, 2'b00};
                tgtLanesN <= ~decActive;
                tgtWidth <= decWidth;
                tgtWrData <= bus.data;
            end else if (busy) begin
                if (waitCnt != 4'h0) begin
                    waitCnt <= waitCnt - 4'h1;
                end else begin
                    busy <= 1'b0;
                    bus.readyN <= 1'b0;
                    bus.perData <= steerRd;
                    bus.perDataOe <= !tgtWrite;
                end
            end
            // Write bytes gathered down to the narrow target's low lanes
            if (tgtStrobe && tgtWrite) begin
                if (curWidth == dbs_pkg::DBS_W8) begin
                    for (int k = 0; k < 4; k++) begin
                        if (lowest[k]) begin
                            tgtWrData <= {24'h0, bus.data[k*8 +: 8]};
                        end
                    end
                end else if (curWidth == dbs_pkg::DBS_W16 &&
                             curActive[1:0] == 2'b00) begin
                    tgtWrData <= {16'h0, bus.data[31:16]};
                end
            end
        end
    end
endmodule // dbs_periph_end

// ---- sim/dbs_link_asserts.sv ----
// Timing and lane checks on the bus between the two ends
module dbs_link_asserts #(
    parameter logic [3:0] WAIT_STATES = 4'h1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic addrStrobeN,
    input wire logic [31:2] addr,
    input wire logic [3:0] laneSelectN,
    input wire logic ioCycle,
    input wire logic writeCycle,
    input wire logic [31:0] cpuData,
    input wire logic cpuDataOe,
    input wire logic perDataOe,
    input wire logic readyN,
    input wire logic halfWidthRequestN,
    input wire logic byteWidthRequestN
);
    localparam int RDY_LAT = int'(WAIT_STATES) + 2;
    logic [3:0] curLanes;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    function automatic logic [3:0] nxt8(input logic [3:0] l);
        return l | (~l & (l + 4'h1));
    endfunction
    function automatic logic [3:0] nxt16(input logic [3:0] l);
        return (l[1:0] != 2'h3) ? (l | 4'h3) : 4'hf;
    endfunction
    function automatic logic [31:0] mask(input logic [3:0] l);
        return {{8{!l[3]}}, {8{!l[2]}}, {8{!l[1]}}, {8{!l[0]}}};
    endfunction
    // Lanes of the cycle in flight; the bus may idle them to f
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            curLanes <= 4'hf;
        end else if (!addrStrobeN) begin
            curLanes <= laneSelectN;
        end
    end
    property p_rdy_lat;
        !addrStrobeN |-> ##RDY_LAT !readyN;
    endproperty
    a_rdy_lat: assert property (p_rdy_lat)
        else $error("ready late or early after strobe");
    property p_rdy_pulse;
        !readyN |=> readyN;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse)
        else $error("ready held longer than one cycle");
    property p_stb_pulse;
        !addrStrobeN |=> addrStrobeN;
    endproperty
    a_stb_pulse: assert property (p_stb_pulse)
        else $error("strobe held longer than one cycle");
    property p_width_hold;
        addrStrobeN && $past(addrStrobeN) |->
            $stable(halfWidthRequestN) && $stable(byteWidthRequestN);
    endproperty
    a_width_hold: assert property (p_width_hold)
        else $error("width request moved inside a bus cycle");
    property p_follow8;
        !readyN && !$past(byteWidthRequestN) && nxt8(curLanes) != 4'hf
            |=> !addrStrobeN && laneSelectN == nxt8($past(curLanes))
            && $stable(addr);
    endproperty
    a_follow8: assert property (p_follow8)
        else $error("byte width follow-on lanes wrong");
    property p_follow16;
        !readyN && $past(byteWidthRequestN) && !$past(halfWidthRequestN)
            && nxt16(curLanes) != 4'hf
            |=> !addrStrobeN && laneSelectN == nxt16($past(curLanes))
            && $stable(addr);
    endproperty
    a_follow16: assert property (p_follow16)
        else $error("half width follow-on lanes wrong");
    property p_wr_lanes;
        !addrStrobeN && writeCycle && cpuDataOe |->
            (cpuData & ~mask(laneSelectN)) == 32'h0;
    endproperty
    a_wr_lanes: assert property (p_wr_lanes)
        else $error("write data on unselected lanes");
    property p_io_range;
        !addrStrobeN && ioCycle |-> addr[31:16] == 16'h0;
    endproperty
    a_io_range: assert property (p_io_range)
        else $error("io address above 64 KB");
    property p_rd_drive;
        perDataOe |-> !readyN && !writeCycle;
    endproperty
    a_rd_drive: assert property (p_rd_drive)
        else $error("peripheral drives data outside read ready");
    c_byte: cover property (!readyN && !byteWidthRequestN);
    c_half: cover property (!readyN && !halfWidthRequestN);
    c_both: cover property (!readyN && !halfWidthRequestN &&
        !byteWidthRequestN);
    c_io: cover property (!addrStrobeN && ioCycle && !writeCycle);
endmodule // dbs_link_asserts

// ---- sim/tb_top.sv ----
// Self-checking bench: both link ends joined, random and corner requests
`include "dbs_params.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic reqValid = 1'h0, reqWrite = 1'h0, reqIo = 1'h0, reqLine = 1'h0;
    logic [31:0] reqAddr = 32'h0, reqWrData = 32'h0, expWr = 32'h0;
    logic [3:0] reqLanesN = 4'hf, busLanes = 4'hf;
    logic reqReady, respValid, writesPending, tgtStrobe, tgtWrite, tgtIo;
    logic [31:0] respData, tgtAddr, tgtWrData, tgtRdData;
    logic [3:0] tgtLanesN;
    dbs_pkg::dbs_width_e tgtWidth;
    logic [31:0] seed = 32'h2584;
    logic curLine = 1'h0;
    logic wrSeen = 1'h0;
    logic [31:0] wrMask, wrExp;
    int n_mismatch = 0, compares = 0, cycles = 0, nStrobe = 0;
    logic [31:0] addrT [6] = '{32'hf000_0010, 32'he000_0020, 32'h3000_0030,
        32'h0000_0040, 32'h7a5c_1050, 32'h0000_5060};
    logic [3:0] laneT [8] = '{4'h0, 4'h8, 4'h1, 4'h9, 4'h3, 4'h7, 4'hc, 4'he};
    dbs_bus_if bus ();
    always #5 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [31:0] memVal(input logic [31:0] a);
        return (a * 32'h9e37_79b1) ^ 32'h5a5a_0ff0;
    endfunction
    function automatic logic [2:0] wOf(input logic io, input logic [31:0] a);
        logic [3:0] t;
        t = io ? a[15:12] : a[31:28];
        if (t == (io ? `DBS_IO8_TAG : `DBS_MEM8_TAG)) return 3'h4;
        if (t == (io ? `DBS_IO16_TAG : `DBS_MEM16_TAG)) return 3'h2;
        return 3'h1;
    endfunction
    function automatic int nCyc(input logic [3:0] l, input logic [2:0] w);
        if (w == 3'h1) return 1;
        if (w == 3'h2) return int'(l[1:0] != 2'h3) + int'(l[3:2] != 2'h3);
        return 4 - $countones(l);
    endfunction
    function automatic logic [31:0] mask(input logic [3:0] l);
        return {{8{!l[3]}}, {8{!l[2]}}, {8{!l[1]}}, {8{!l[0]}}};
    endfunction
    // Narrow targets see their bytes low-aligned, cut to their width
    function automatic logic [31:0] nat(input logic [31:0] d,
        input logic [3:0] l, input logic [2:0] w);
        if (w == 3'h4) return (l[0] ? (l[1] ? (l[2] ? d >> 24 : d >> 16)
            : d >> 8) : d) & 32'hff;
        if (w == 3'h2) return (l[1:0] == 2'h3 ? d >> 16 : d) & 32'hffff;
        return d;
    endfunction
    function automatic logic [31:0] nativeRd(input logic [31:0] a,
        input logic [3:0] l, input logic [2:0] w);
        return nat(memVal(a), l, w);
    endfunction
    assign tgtRdData = nativeRd(tgtAddr, tgtLanesN, tgtWidth);
    dbs_cpu_end dbs_cpu_end_inst (.clk(clk), .rst_b(rst_b), .bus(bus),
        .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite),
        .reqIo(reqIo), .reqLine(reqLine), .reqAddr(reqAddr),
        .reqLanesN(reqLanesN), .reqWrData(reqWrData),
        .respValid(respValid), .respData(respData),
        .writesPending(writesPending));
    dbs_periph_end #(.WAIT_STATES(4'h1)) dbs_periph_end_inst (.clk(clk),
        .rst_b(rst_b), .bus(bus), .tgtStrobe(tgtStrobe),
        .tgtWrite(tgtWrite), .tgtIo(tgtIo), .tgtAddr(tgtAddr),
        .tgtLanesN(tgtLanesN), .tgtWidth(tgtWidth),
        .tgtWrData(tgtWrData), .tgtRdData(tgtRdData));
    dbs_link_asserts #(.WAIT_STATES(4'h1)) dbs_link_asserts_inst (
        .clk(clk), .rst_b(rst_b), .addrStrobeN(bus.addrStrobeN),
        .addr(bus.addr), .laneSelectN(bus.laneSelectN),
        .ioCycle(bus.ioCycle), .writeCycle(bus.writeCycle),
        .cpuData(bus.cpuData), .cpuDataOe(bus.cpuDataOe),
        .perDataOe(bus.perDataOe), .readyN(bus.readyN),
        .halfWidthRequestN(bus.halfWidthRequestN),
        .byteWidthRequestN(bus.byteWidthRequestN));
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    always @(negedge clk) begin
        // Gathered write data stands the cycle after the target strobe
        if (wrSeen) begin
            wrMask = nat(mask(tgtLanesN), tgtLanesN, tgtWidth);
            wrExp = nat(expWr, tgtLanesN, tgtWidth) & wrMask;
            `CHK("tgtWrData", wrExp, tgtWrData & wrMask)
        end
        wrSeen = tgtStrobe === 1'h1 && tgtWrite === 1'h1;
        if (!bus.addrStrobeN) begin
            nStrobe++;
            busLanes = bus.laneSelectN;
            if (bus.ioCycle && !bus.writeCycle)
                `CHK("writesPending", 1'h0, writesPending)
        end
        if (tgtStrobe === 1'h1) begin
            `CHK("tgtWidth", wOf(tgtIo, tgtAddr), tgtWidth)
            if (curLine && !tgtIo) `CHK("tgtLanesN", 4'h0, tgtLanesN)
        end
        if (!bus.readyN && bus.writeCycle)
            `CHK("data", expWr & mask(busLanes), bus.data & mask(busLanes))
    end
    // Leaves reqValid up so a second request can follow at once
    task automatic issue(input logic w, io, ln, input logic [31:0] a,
        input logic [3:0] l);
        seed = xs(seed);
        reqValid <= 1'h1;
        reqWrite <= w;
        reqIo <= io;
        reqLine <= ln;
        reqAddr <= a;
        reqLanesN <= l;
        curLine = ln;
        if (w) begin
            reqWrData <= seed;
            expWr = seed;
        end
        do @(negedge clk); while (reqReady !== 1'h1);
        @(posedge clk);
    endtask
    task automatic runReq(input logic w, io, ln, input logic [31:0] a,
        input logic [3:0] l);
        logic [31:0] ea;
        ea = (io ? a & `DBS_IO_ADDR_MASK : a) & 32'hffff_fffc;
        nStrobe = 0;
        issue(w, io, ln, a, l);
        reqValid <= 1'h0;
        do @(negedge clk); while (respValid !== 1'h1);
        if (!w) `CHK("respData", memVal(ea) & mask(l), respData & mask(l))
        while (writesPending !== 1'h0) @(negedge clk);
        `CHK("nStrobe", nCyc(l, wOf(io, ea)), nStrobe)
        @(posedge clk);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'h1;
        repeat (2) @(posedge clk);
        for (int a = 0; a < 6; a++)
            for (int l = 0; l < 8; l++)
                for (int w = 0; w < 2; w++)
                    runReq(w[0], a >= 3, 1'h0, addrT[a], laneT[l]);
        $display("test corners done");
        runReq(1'h0, 1'h0, 1'h1, 32'h3000_0100, 4'hc);
        $display("test line read done");
        // Posted slow write then an I/O read right behind it
        issue(1'h1, 1'h0, 1'h0, 32'hf000_0200, 4'h0);
        issue(1'h0, 1'h1, 1'h0, 32'h0000_0300, 4'h0);
        reqValid <= 1'h0;
        do @(negedge clk); while (respValid !== 1'h1);
        `CHK("respData", memVal(32'h0000_0300), respData)
        @(posedge clk);
        $display("test io order done");
        for (int i = 0; i < 40; i++) begin
            logic [31:0] a;
            int s, n;
            seed = xs(seed);
            s = seed[13:12];
            n = 1 + seed[15:14] % (4 - s);
            a = addrT[seed[2:0] % 6] | {22'h0, seed[11:4], 2'h0};
            if (a[31:16] == 16'h0 || a[31:16] == 16'h7a5c) a[31:16] = seed[31:16];
            runReq(seed[16], seed[2:0] % 6 >= 3, 1'h0, a,
                ~(((4'h1 << n) - 4'h1) << s));
        end
        $display("test random done");
        finish_test();
    end
endmodule // tb_top
